// ---- tcsu_pkg.sv ----
// constants for the upper timer control/status block
// Overview of operation
// - upper overflow flag bit 7 sets when upper count byte wraps FF to 00.
// - overflow flag clears only on write zero after it was read as one.
// - upper match flag bit 6 sets when upper count equals upper compare (8-bit mode) or full count equals compare (16-bit mode).
// - match flag clears only on write zero after it was read as one.
// - overflow interrupt enable bit 5 gates the overflow interrupt request.
// - 16-bit mode: clear select bit 4 clears combined counter on combined match.
// - 8-bit mode: clear select clears only upper count byte on upper match.
package tcsu_pkg;
    localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_IRQ_MASK    = 12'h008;
    localparam logic [11:0] ADDR_COUNT       = 12'h00C;
    localparam logic [11:0] ADDR_COMPARE     = 12'h010;
    localparam logic [11:0] ADDR_MODE        = 12'h014;
    localparam int BIT_OVF   = 7;
    localparam int BIT_MATCH = 6;
    localparam int BIT_OVIE  = 5;
    localparam int BIT_CCLR  = 4;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [1:0]  IRQ_RESET     = 2'h0;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
    localparam logic [7:0]  BYTE_ALL_ONES = 8'hFF;
endpackage

// ---- tcsu_timer_ctrl.sv ----
// upper timer control/status register with its counter and apb slave
`timescale 1ns/10ps
module tcsu_timer_ctrl
    import tcsu_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic             overflowIrqReq
);
    // registers
    logic        ovf_r, ovf_nxt;
    logic        match_r, match_nxt;
    logic        ovie_r, ovie_nxt;
    logic        cclr_r, cclr_nxt;
    logic        ovfSeen_r, ovfSeen_nxt;
    logic        matchSeen_r, matchSeen_nxt;
    logic [1:0]  irqStat_r, irqStat_nxt;
    logic [1:0]  irqMask_r, irqMask_nxt;
    logic [15:0] count_r, count_nxt;
    logic [15:0] compare_r, compare_nxt;
    logic        mode16_r, mode16_nxt;
    logic        run_r, run_nxt;
    logic [31:0] prdata_r, prdata_nxt;

    logic access, wr, rd, mapped, rdSetup;
    logic upperWrap, upperMatch, fullMatch, ovfSet, matchSet;
    logic ctrlWr, ctrlRd;

    assign access  = psel && penable;
    assign wr      = access && pwrite;
    assign rd      = access && !pwrite;
    assign mapped  = paddr == ADDR_CTRL_STATUS || paddr == ADDR_IRQ_STATUS || paddr == ADDR_IRQ_MASK
                  || paddr == ADDR_COUNT || paddr == ADDR_COMPARE || paddr == ADDR_MODE;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = prdata_r;
    assign ctrlWr  = wr && paddr == ADDR_CTRL_STATUS;
    assign ctrlRd  = rd && paddr == ADDR_CTRL_STATUS;
    // read data captured in the setup cycle so it already stands at the zero-wait access edge
    assign rdSetup = psel && !penable && !pwrite;

    // upper byte events; in 8-bit mode the low byte is ignored for compare
    assign upperWrap  = run_r && count_r[15:8] == BYTE_ALL_ONES
                     && (mode16_r ? count_r[7:0] == BYTE_ALL_ONES : 1'b1);
    assign upperMatch = count_r[15:8] == compare_r[15:8];
    assign fullMatch  = count_r == compare_r;
    assign ovfSet     = upperWrap;
    assign matchSet   = mode16_r ? fullMatch : upperMatch;

    always_comb begin
        ovf_nxt       = ovf_r;
        match_nxt     = match_r;
        ovie_nxt      = ovie_r;
        cclr_nxt      = cclr_r;
        ovfSeen_nxt   = ovfSeen_r;
        matchSeen_nxt = matchSeen_r;
        irqStat_nxt   = irqStat_r;
        irqMask_nxt   = irqMask_r;
        count_nxt     = count_r;
        compare_nxt   = compare_r;
        mode16_nxt    = mode16_r;
        run_nxt       = run_r;
        prdata_nxt    = prdata_r;
        // read of one arms the clear; armed from the value software
        // actually receives, not from a flag that set after capture
        if (ctrlRd && prdata_r[BIT_OVF]) begin
            ovfSeen_nxt = 1'b1;
        end
        if (ctrlRd && prdata_r[BIT_MATCH]) begin
            matchSeen_nxt = 1'b1;
        end
        if (ctrlWr) begin
            ovie_nxt = pwdata[BIT_OVIE];
            cclr_nxt = pwdata[BIT_CCLR];
            if (!pwdata[BIT_OVF] && ovfSeen_r) begin
                ovf_nxt     = 1'b0;
                ovfSeen_nxt = 1'b0;
            end
            if (!pwdata[BIT_MATCH] && matchSeen_r) begin
                match_nxt     = 1'b0;
                matchSeen_nxt = 1'b0;
            end
        end
        // set beats a clear in the same cycle
        if (ovfSet) begin
            ovf_nxt = 1'b1;
        end
        if (matchSet) begin
            match_nxt = 1'b1;
        end
        // counter: clear on match, otherwise count while running
        if (run_r) begin
            if (cclr_r && mode16_r && fullMatch) begin
                count_nxt = COUNT_RESET;
            end else if (cclr_r && !mode16_r && upperMatch) begin
                count_nxt = {8'h00, count_r[7:0] + 8'h01};
            end else if (mode16_r) begin
                count_nxt = count_r + 16'h0001;
            end else begin
                count_nxt = {count_r[15:8] + 8'h01, count_r[7:0] + 8'h01};
            end
        end
        if (wr && paddr == ADDR_COUNT) begin
            count_nxt = pwdata[15:0];
        end
        if (wr && paddr == ADDR_COMPARE) begin
            compare_nxt = pwdata[15:0];
        end
        if (wr && paddr == ADDR_MODE) begin
            mode16_nxt = pwdata[0];
            run_nxt    = pwdata[1];
        end
        if (wr && paddr == ADDR_IRQ_MASK) begin
            irqMask_nxt = pwdata[1:0];
        end
        if (wr && paddr == ADDR_IRQ_STATUS) begin
            irqStat_nxt = irqStat_r & ~pwdata[1:0];
        end
        // sticky status: bit0 overflow, bit1 match; set wins over w1c
        irqStat_nxt = irqStat_nxt | {matchSet, ovfSet && ovie_r};
        if (rdSetup) begin
            unique case (paddr)
                ADDR_CTRL_STATUS: prdata_nxt = {24'h000000, ovf_r, match_r, ovie_r, cclr_r, 4'h0};
                ADDR_IRQ_STATUS:  prdata_nxt = {30'h00000000, irqStat_r};
                ADDR_IRQ_MASK:    prdata_nxt = {30'h00000000, irqMask_r};
                ADDR_COUNT:       prdata_nxt = {16'h0000, count_r};
                ADDR_COMPARE:     prdata_nxt = {16'h0000, compare_r};
                ADDR_MODE:        prdata_nxt = {30'h00000000, run_r, mode16_r};
                default:          prdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ovf_r       <= CTRL_RESET[BIT_OVF];
            match_r     <= CTRL_RESET[BIT_MATCH];
            ovie_r      <= CTRL_RESET[BIT_OVIE];
            cclr_r      <= CTRL_RESET[BIT_CCLR];
            ovfSeen_r   <= 1'b0;
            matchSeen_r <= 1'b0;
            irqStat_r   <= IRQ_RESET;
            irqMask_r   <= IRQ_RESET;
            count_r     <= COUNT_RESET;
            compare_r   <= COMPARE_RESET;
            mode16_r    <= 1'b0;
            run_r       <= 1'b0;
            prdata_r    <= 32'h00000000;
        end else begin
            ovf_r       <= ovf_nxt;
            match_r     <= match_nxt;
            ovie_r      <= ovie_nxt;
            cclr_r      <= cclr_nxt;
            ovfSeen_r   <= ovfSeen_nxt;
            matchSeen_r <= matchSeen_nxt;
            irqStat_r   <= irqStat_nxt;
            irqMask_r   <= irqMask_nxt;
            count_r     <= count_nxt;
            compare_r   <= compare_nxt;
            mode16_r    <= mode16_nxt;
            run_r       <= run_nxt;
            prdata_r    <= prdata_nxt;
        end
    end

    assign irq            = |(irqStat_r & irqMask_r);
    assign overflowIrqReq = ovf_r && ovie_r;

    property p_ovf_set;
        @(posedge clk) disable iff (reset) ovfSet |=> ovf_r;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set after wrap");

    property p_ovf_hold;
        @(posedge clk) disable iff (reset) (ctrlWr && !pwdata[BIT_OVF] && !ovfSeen_r && ovf_r) |=> ovf_r;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag cleared without read");

    property p_match_set;
        @(posedge clk) disable iff (reset) matchSet |=> match_r;
    endproperty
    a_match_set: assert property (p_match_set) else $error("match flag not set");

    property p_match_clr;
        @(posedge clk) disable iff (reset) $fell(match_r) |-> $past(matchSeen_r) && $past(ctrlWr);
    endproperty
    a_match_clr: assert property (p_match_clr) else $error("match flag cleared illegally");

    property p_ovie;
        @(posedge clk) disable iff (reset) overflowIrqReq |-> ovie_r && ovf_r;
    endproperty
    a_ovie: assert property (p_ovie) else $error("overflow request without enable");

    property p_clr16;
        @(posedge clk) disable iff (reset)
            (run_r && mode16_r && cclr_r && fullMatch && !wr) |=> count_r == COUNT_RESET;
    endproperty
    a_clr16: assert property (p_clr16) else $error("combined counter not cleared on match");

    property p_clr8;
        @(posedge clk) disable iff (reset)
            (run_r && !mode16_r && cclr_r && upperMatch && !wr) |=> count_r[15:8] == 8'h00;
    endproperty
    a_clr8: assert property (p_clr8) else $error("upper byte not cleared on match");

    property p_set_wins;
        @(posedge clk) disable iff (reset) (ctrlWr && ovfSeen_r && ovfSet) |=> ovf_r;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("overflow event lost on clear");

    property p_ovf_clr;
        @(posedge clk) disable iff (reset) (ctrlWr && !pwdata[BIT_OVF] && ovfSeen_r && !ovfSet) |=> !ovf_r;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("armed overflow clear ignored");

    property p_match_hold;
        @(posedge clk) disable iff (reset) (ctrlWr && !pwdata[BIT_MATCH] && !matchSeen_r && match_r) |=> match_r;
    endproperty
    a_match_hold: assert property (p_match_hold) else $error("match flag cleared without read");

    property p_match_wins;
        @(posedge clk) disable iff (reset) (ctrlWr && matchSeen_r && matchSet) |=> match_r;
    endproperty
    a_match_wins: assert property (p_match_wins) else $error("match event lost on clear");

    property p_ovie_off;
        @(posedge clk) disable iff (reset) !ovie_r |-> !overflowIrqReq;
    endproperty
    a_ovie_off: assert property (p_ovie_off) else $error("overflow request while disabled");

    property p_irq_ovf;
        @(posedge clk) disable iff (reset) (ovfSet && ovie_r) |=> irqStat_r[0];
    endproperty
    a_irq_ovf: assert property (p_irq_ovf) else $error("enabled overflow not latched");

    // plain counting paths, so the clear paths cannot hide a stuck counter
    property p_count16;
        @(posedge clk) disable iff (reset)
            (run_r && mode16_r && !(cclr_r && fullMatch) && !wr) |=> count_r == $past(count_r) + 16'h0001;
    endproperty
    a_count16: assert property (p_count16) else $error("combined counter did not step");

    property p_run8;
        @(posedge clk) disable iff (reset)
            (run_r && !mode16_r && !(cclr_r && upperMatch) && !wr) |=> count_r[15:8] == $past(count_r[15:8]) + 8'h01;
    endproperty
    a_run8: assert property (p_run8) else $error("upper byte did not step");

    property p_stopped;
        @(posedge clk) disable iff (reset) (!run_r && !wr) |=> $stable(count_r);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

    property p_prdata_hold;
        @(posedge clk) disable iff (reset) !rdSetup |=> $stable(prdata_r);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold) else $error("read data changed without a read");

    property p_w1c;
        @(posedge clk) disable iff (reset)
            (wr && paddr == ADDR_IRQ_STATUS && pwdata[1] && !matchSet) |=> !irqStat_r[1];
    endproperty
    a_w1c: assert property (p_w1c) else $error("match status not cleared by one");

    property p_mask_wr;
        @(posedge clk) disable iff (reset) (wr && paddr == ADDR_IRQ_MASK) |=> irqMask_r == $past(pwdata[1:0]);
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

    c_ovf:   cover property (@(posedge clk) disable iff (reset) $rose(ovf_r));
    c_clr:   cover property (@(posedge clk) disable iff (reset) $fell(ovf_r));
    c_irq:   cover property (@(posedge clk) disable iff (reset) $rose(irq));
    c_match: cover property (@(posedge clk) disable iff (reset) $rose(match_r) ##[1:1000] $fell(match_r));
    c_clr8:  cover property (@(posedge clk) disable iff (reset) run_r && !mode16_r && cclr_r && upperMatch);
endmodule

// ---- tcsu_timer_ctrl_tb.sv ----
// self-checking bench for the upper timer control/status block
`timescale 1ns/10ps
module tcsu_timer_ctrl_tb
    import tcsu_pkg::*;
();
    typedef struct {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic        s;
    } tcsu_row_t;

    logic        clk;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        overflowIrqReq;
    logic        err;
    int          nErrors;
    int          cmpCount;
    // writes of one to the flags must not set them; unmapped reads give zero
    tcsu_row_t   rows[8] = '{'{ADDR_CTRL_STATUS, 32'hF0, 32'h30, 1'b0}, '{ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h3, 1'b0},
                           '{ADDR_COMPARE, 32'h1234, 32'h1234, 1'b0}, '{ADDR_COUNT, 32'hFFFF00AB, 32'hAB, 1'b0},
                           '{ADDR_MODE, 32'h1, 32'h1, 1'b0}, '{ADDR_MODE, 32'h0, 32'h0, 1'b0},
                           '{ADDR_CTRL_STATUS, 32'h0, 32'h0, 1'b0}, '{12'h020, 32'h5, 32'h0, 1'b1}};

    tcsu_timer_ctrl u_dut (
        .clk            (clk),
        .reset          (reset),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .irq            (irq),
        .overflowIrqReq (overflowIrqReq)
    );

    always #12.5 clk = ~clk;

    task automatic results;
        $display("errors=%0d compares=%0d", nErrors, cmpCount);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // answer taken at the edge where pready is seen high; later checks wait for the fall
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n >= 50) nErrors++;
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic run(input logic [31:0] mode, input int cycles);
        apb(1'b1, ADDR_MODE, mode);
        repeat (cycles) @(posedge clk);
        apb(1'b1, ADDR_MODE, 32'h0);
    endtask

    initial begin
        #250000;
        nErrors++;
        results;
    end

    initial begin
        {clk, reset, psel, penable, pwrite, paddr, pwdata, nErrors, cmpCount} = '0;
        reset = 1'b1;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        chk(irq, 1'b0);
        rdc(ADDR_CTRL_STATUS, CTRL_RESET);
        rdc(ADDR_COMPARE, COMPARE_RESET);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            chk(err, rows[i].s);
            rdc(rows[i].a, rows[i].e);
        end
        apb(1'b1, ADDR_IRQ_MASK, 32'h2);
        // 8-bit mode: upper byte wraps on the first counting edge
        apb(1'b1, ADDR_COUNT, 32'hFF00);
        apb(1'b1, ADDR_COMPARE, 32'h8000);
        run(32'h2, 20);
        chk(overflowIrqReq, 1'b0);
        apb(1'b1, ADDR_CTRL_STATUS, 32'h20);
        chk(overflowIrqReq, 1'b1);
        rdc(ADDR_CTRL_STATUS, 32'hA0);
        apb(1'b1, ADDR_CTRL_STATUS, 32'h20);
        rdc(ADDR_CTRL_STATUS, 32'h20);
        chk(overflowIrqReq, 1'b0);
        // clearing at 05 keeps the upper byte from ever wrapping
        apb(1'b1, ADDR_CTRL_STATUS, 32'h10);
        apb(1'b1, ADDR_COMPARE, 32'h0500);
        apb(1'b1, ADDR_COUNT, 32'h0);
        run(32'h2, 300);
        chk(irq, 1'b1);
        rdc(ADDR_CTRL_STATUS, 32'h50);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk(rd[15:8] <= 8'h05, 1'b1);
        apb(1'b1, ADDR_COMPARE, 32'hFF00);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h2);
        chk(irq, 1'b1);
        apb(1'b1, ADDR_IRQ_STATUS, 32'h2);
        chk(irq, 1'b0);
        apb(1'b1, ADDR_CTRL_STATUS, 32'h10);
        rdc(ADDR_CTRL_STATUS, 32'h10);
        apb(1'b1, ADDR_COMPARE, 32'h0010);
        apb(1'b1, ADDR_COUNT, 32'h0);
        run(32'h3, 300);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk(rd <= 32'h10, 1'b1);
        apb(1'b1, ADDR_CTRL_STATUS, 32'h0);
        apb(1'b1, ADDR_COUNT, 32'h0);
        run(32'h3, 40);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk(rd > 32'h10, 1'b1);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdc(ADDR_COMPARE, COMPARE_RESET);
        rdc(ADDR_CTRL_STATUS, CTRL_RESET);
        results;
    end
endmodule
